//--- rtl/pic_map.svh
/*
  register offsets, field positions, reset values and vectors of the prioritized interrupt controller.
  assumes: included by the controller module only.
*/
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_OFS_WORD0 4'h0
`define PIC_OFS_WORD1 4'h1
`define PIC_OFS_WORD2 4'h2
`define PIC_OFS_WORD3 4'h3
`define PIC_OFS_STATUS 4'h4
`define PIC_OFS_PORTB 4'h5
`define PIC_BIT_GIE 0
`define PIC_BIT_EXT0_FLAG 2
`define PIC_BIT_EXT0_MASK 3
`define PIC_BIT_EXT1_FLAG 0
`define PIC_BIT_EXT1_MASK 1
`define PIC_BIT_TA_FLAG 2
`define PIC_BIT_TA_MASK 3
`define PIC_BIT_TB_FLAG 0
`define PIC_BIT_TB_MASK 1
`define PIC_BIT_TC_FLAG 2
`define PIC_BIT_TC_MASK 3
`define PIC_BIT_AD_FLAG 0
`define PIC_BIT_AD_MASK 1
`define PIC_BIT_SER_FLAG 2
`define PIC_BIT_SER_MASK 3
`define PIC_BIT_RAM_VALID 3
`define PIC_BIT_PORTB3 3
`define PIC_RST_FLAGS 7'h00
`define PIC_RST_MASKS 7'h7f
`define PIC_VEC_RESET 16'h0000
`define PIC_VEC_BASE 16'h0002
`define PIC_VEC_STEP 16'h0002
`endif

//--- rtl/pic_pkg.sv
/*
  types of the prioritized interrupt controller.
  assumes: pic_map.svh holds every number.
*/
package pic_pkg;
  typedef enum logic [3:0] {
    PIC_IDLE = 4'b0001,
    PIC_FINISH = 4'b0010,
    PIC_PUSH = 4'b0100,
    PIC_JUMP = 4'b1000
  } pic_seq_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } pic_bus_t;
  typedef struct packed {
    logic timer_a;
    logic timer_b;
    logic timer_c;
    logic conv_done;
    logic ser_done;
    logic ser_susp;
  } pic_evt_t;
  typedef struct packed {
    pic_seq_t seq;
    logic gie;
    logic [6:0] flags;
    logic [6:0] masks;
    logic [2:0] src;
    logic [2:0] sync0;
    logic [2:0] sync1;
    logic [2:0] syncs;
    logic ram_valid;
    logic portb3;
    logic [3:0] rdata;
    logic [15:0] vector;
    logic vec_valid;
    logic push;
    logic restart;
  } pic_state_t;
endpackage

//--- rtl/pic_ctrl.sv
/*
  prioritized interrupt controller: seven masked sources with fixed priority, global enable,
  three-cycle acceptance sequence with vector output, stop-cancel vectoring and ram-valid status.
  assumes: one 40 MHz clock, asynchronous active-low reset, cpu drives the register port,
  peripherals give one-cycle event pulses on sys_clk, external pins and stop-cancel are asynchronous.
*/
// Contract
// - reset and stop-cancel vector to 0000; sources to 0002..000E in two-word steps.
// - accept source when enable set, flag set, mask clear, no higher pending.
// - stop-cancel honoured only in stop mode, ignored otherwise.
// - global enable at word0 bit0; cleared on acceptance, set by return-from-interrupt.
// - external flags set on rising edge of external inputs.
// - external masks block when 1, allow when 0.
// - timer A overflow sets timer A flag.
// - timer A mask blocks when 1.
// - timer B overflow sets timer B flag.
// - timer B mask blocks when 1.
// - timer C overflow sets timer C flag.
// - timer C mask blocks when 1.
// - serial flag set on transfer complete or suspend.
// - serial mask blocks when 1.
// - converter flag set on conversion finish.
// - converter mask blocks when 1.
// - ram-valid set by stop-cancel exit, cleared by any other reset.
// - port-b bit3 kept on stop-cancel exit, cleared on other reset.
// - cpu working state not preserved; nothing kept here for it.
// - cycle1 finish, cycle2 clear enable and push, cycle3 push and jump.
// - reset clears enable and flags, sets all masks.
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_ctrl
  import pic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // pins
  input wire logic ext_irq_input_0,
  input wire logic ext_irq_input_1,
  input wire logic stop_cancel_input,
  // peripheral events, one-cycle pulses
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic timer_c_ovf,
  input wire logic conv_done,
  input wire logic ser_done,
  input wire logic ser_susp,
  // cpu side
  input wire logic stop_mode,
  input wire logic return_from_interrupt_instr,
  output logic irq_finish,
  output logic irq_push,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic cpu_restart,
  output logic ram_valid_flag,
  output logic port_mode_b_bit3
);
  pic_bus_t bus;
  pic_evt_t evt;
  pic_state_t s_q, s_d;
  logic [6:0] pend;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign evt = '{timer_a: timer_a_ovf, timer_b: timer_b_ovf, timer_c: timer_c_ovf,
                 conv_done: conv_done, ser_done: ser_done, ser_susp: ser_susp};

  // index 0 is external 0 (highest) through 6 serial (lowest)
  function automatic logic [2:0] pic_first(input logic [6:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (p[i]) r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic [15:0] pic_vec(input logic [2:0] idx);
    return `PIC_VEC_BASE + 16'(idx) * `PIC_VEC_STEP;
  endfunction

  // a rise counts once first and second stage are high and the third is low; the third stage holds the second stage's level of the last cycle
  function automatic logic pic_rise(input logic [2:0] sy);
    return sy[1] & sy[0] & ~sy[2];
  endfunction

  // stop-cancel edge seen this cycle, used by the checks; the logic takes it from pic_rise directly
  function automatic logic cancel_now();
    return pic_rise(s_q.syncs);
  endfunction

  assign pend = s_q.flags & ~s_q.masks;

  always_comb begin
    logic [6:0] set;
    logic [6:0] clr;
    logic rise0;
    logic rise1;
    logic cancel;
    set = 7'h00;
    clr = 7'h00;
    rise0 = 1'b0;
    rise1 = 1'b0;
    cancel = 1'b0;
    s_d = s_q;
    s_d.sync0 = {s_q.sync0[1:0], ext_irq_input_0};
    s_d.sync1 = {s_q.sync1[1:0], ext_irq_input_1};
    s_d.syncs = {s_q.syncs[1:0], stop_cancel_input};
    // agreed level rises: stages 1 and 2 high while stage 2 was low last cycle
    rise0 = pic_rise(s_q.sync0);
    rise1 = pic_rise(s_q.sync1);
    cancel = pic_rise(s_q.syncs);
    set[0] = rise0;
    set[1] = rise1;
    set[2] = evt.timer_a;
    set[3] = evt.timer_b;
    set[4] = evt.timer_c;
    set[5] = evt.conv_done;
    set[6] = evt.ser_done | evt.ser_susp;
    s_d.rdata = 4'h0;
    s_d.push = 1'b0;
    s_d.vec_valid = 1'b0;
    s_d.restart = 1'b0;
    if (bus.rd) begin
      case (bus.addr)
        `PIC_OFS_WORD0: s_d.rdata = {s_q.masks[0], s_q.flags[0], 1'b0, s_q.gie};
        `PIC_OFS_WORD1: s_d.rdata = {s_q.masks[2], s_q.flags[2], s_q.masks[1], s_q.flags[1]};
        `PIC_OFS_WORD2: s_d.rdata = {s_q.masks[4], s_q.flags[4], s_q.masks[3], s_q.flags[3]};
        `PIC_OFS_WORD3: s_d.rdata = {s_q.masks[6], s_q.flags[6], s_q.masks[5], s_q.flags[5]};
        `PIC_OFS_STATUS: s_d.rdata = {s_q.ram_valid, 3'h0};
        `PIC_OFS_PORTB: s_d.rdata = {s_q.portb3, 3'h0};
        default: s_d.rdata = 4'h0;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        `PIC_OFS_WORD0: begin
          s_d.gie = bus.wdata[`PIC_BIT_GIE];
          clr[0] = ~bus.wdata[`PIC_BIT_EXT0_FLAG];
          s_d.masks[0] = bus.wdata[`PIC_BIT_EXT0_MASK];
        end
        `PIC_OFS_WORD1: begin
          clr[1] = ~bus.wdata[`PIC_BIT_EXT1_FLAG];
          s_d.masks[1] = bus.wdata[`PIC_BIT_EXT1_MASK];
          clr[2] = ~bus.wdata[`PIC_BIT_TA_FLAG];
          s_d.masks[2] = bus.wdata[`PIC_BIT_TA_MASK];
        end
        `PIC_OFS_WORD2: begin
          clr[3] = ~bus.wdata[`PIC_BIT_TB_FLAG];
          s_d.masks[3] = bus.wdata[`PIC_BIT_TB_MASK];
          clr[4] = ~bus.wdata[`PIC_BIT_TC_FLAG];
          s_d.masks[4] = bus.wdata[`PIC_BIT_TC_MASK];
        end
        `PIC_OFS_WORD3: begin
          clr[5] = ~bus.wdata[`PIC_BIT_AD_FLAG];
          s_d.masks[5] = bus.wdata[`PIC_BIT_AD_MASK];
          clr[6] = ~bus.wdata[`PIC_BIT_SER_FLAG];
          s_d.masks[6] = bus.wdata[`PIC_BIT_SER_MASK];
        end
        `PIC_OFS_PORTB: s_d.portb3 = bus.wdata[`PIC_BIT_PORTB3];
        default: ;
      endcase
    end
    // writing 1 to a flag never sets it; hardware is the only setter, and it wins
    s_d.flags = (s_q.flags & ~clr) | set;
    if (return_from_interrupt_instr) s_d.gie = 1'b1;
    case (s_q.seq)
      PIC_IDLE: begin
        if (s_q.gie && pend != 7'h00) begin
          s_d.src = pic_first(pend);
          s_d.seq = PIC_FINISH;
        end
      end
      // outputs are registered, so each cycle's action is prepared one state earlier
      PIC_FINISH: begin
        s_d.gie = 1'b0;
        s_d.push = 1'b1;
        s_d.seq = PIC_PUSH;
      end
      PIC_PUSH: begin
        s_d.push = 1'b1;
        s_d.vec_valid = 1'b1;
        s_d.vector = pic_vec(s_q.src);
        s_d.seq = PIC_JUMP;
      end
      PIC_JUMP: s_d.seq = PIC_IDLE;
      default: s_d.seq = PIC_IDLE;
    endcase
    // stop-cancel exits stop: cpu restarts at 0000, ram and port bit kept; cpu state not saved here
    if (cancel && stop_mode) begin
      s_d.seq = PIC_IDLE;
      s_d.gie = 1'b0;
      s_d.flags = `PIC_RST_FLAGS;
      s_d.masks = `PIC_RST_MASKS;
      s_d.ram_valid = 1'b1;
      s_d.portb3 = s_q.portb3;
      s_d.push = 1'b0;
      s_d.vec_valid = 1'b1;
      s_d.restart = 1'b1;
      s_d.vector = `PIC_VEC_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.seq <= PIC_IDLE;
      s_q.gie <= 1'b0;
      s_q.flags <= `PIC_RST_FLAGS;
      s_q.masks <= `PIC_RST_MASKS;
      s_q.src <= 3'h0;
      s_q.sync0 <= 3'h0;
      s_q.sync1 <= 3'h0;
      s_q.syncs <= 3'h0;
      s_q.ram_valid <= 1'b0;
      s_q.portb3 <= 1'b0;
      s_q.rdata <= 4'h0;
      s_q.vector <= `PIC_VEC_RESET;
      s_q.vec_valid <= 1'b0;
      s_q.push <= 1'b0;
      s_q.restart <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_finish = s_q.seq == PIC_FINISH;
  assign irq_push = s_q.push;
  assign vec_valid = s_q.vec_valid;
  assign vec_addr = s_q.vector;
  assign cpu_restart = s_q.restart;
  assign ram_valid_flag = s_q.ram_valid;
  assign port_mode_b_bit3 = s_q.portb3;

  // assertions
  sequence s_accept;
    s_q.seq == PIC_IDLE && s_q.gie && pend != 7'h00;
  endsequence
  sequence s_walk;
    irq_finish ##1 (irq_push && !s_q.gie) ##1 (vec_valid && irq_push);
  endsequence

  property p_vector;
    @(posedge sys_clk) disable iff (!rst_b)
    s_accept |-> ##3 vec_addr == 16'h0002 + 16'($past(pic_first(pend), 3)) * 16'h0002;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_prio;
    @(posedge sys_clk) disable iff (!rst_b)
    s_accept |=> s_q.src == pic_first($past(pend));
  endproperty
  a_prio: assert property (p_prio) else $error("wrong source chosen");

  property p_no_accept;
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.seq == PIC_IDLE && (!s_q.gie || pend == 7'h00)) |=> !irq_finish;
  endproperty
  a_no_accept: assert property (p_no_accept) else $error("accepted without cause");

  property p_cancel_ignored;
    @(posedge sys_clk) disable iff (!rst_b)
    !stop_mode |=> !cpu_restart;
  endproperty
  a_cancel_ignored: assert property (p_cancel_ignored) else $error("stop-cancel outside stop");

  // a stop-cancel aborts the walk, so stop mode switches this check off
  property p_seq;
    @(posedge sys_clk) disable iff (!rst_b || stop_mode)
    s_accept |=> s_walk;
  endproperty
  a_seq: assert property (p_seq) else $error("acceptance sequence broken");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.flags[2] && !(bus.wr && bus.addr == `PIC_OFS_WORD1) && !cpu_restart) |=> s_q.flags[2] || cpu_restart;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_b)
    (timer_b_ovf && !(cancel_now() && stop_mode)) |=> s_q.flags[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_ram_valid;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(ram_valid_flag) |-> cpu_restart && vec_addr == 16'h0000;
  endproperty
  a_ram_valid: assert property (p_ram_valid) else $error("ram-valid without stop-cancel");

  property p_rti_sets;
    @(posedge sys_clk) disable iff (!rst_b)
    (return_from_interrupt_instr && s_q.seq != PIC_FINISH && !(cancel_now() && stop_mode)) |=> s_q.gie;
  endproperty
  a_rti_sets: assert property (p_rti_sets) else $error("return did not set enable");

  property p_gie_clear;
    @(posedge sys_clk) disable iff (!rst_b)
    irq_finish |=> !s_q.gie;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable kept on acceptance");

  property p_ext0_set;
    @(posedge sys_clk) disable iff (!rst_b)
    ($rose(s_q.sync0[2]) && s_q.sync0[1]) |-> s_q.flags[0] || cpu_restart;
  endproperty
  a_ext0_set: assert property (p_ext0_set) else $error("external 0 edge lost");

  property p_ext1_set;
    @(posedge sys_clk) disable iff (!rst_b)
    ($rose(s_q.sync1[2]) && s_q.sync1[1]) |-> s_q.flags[1] || cpu_restart;
  endproperty
  a_ext1_set: assert property (p_ext1_set) else $error("external 1 edge lost");

  property p_ta_set;
    @(posedge sys_clk) disable iff (!rst_b)
    timer_a_ovf |=> s_q.flags[2] || cpu_restart;
  endproperty
  a_ta_set: assert property (p_ta_set) else $error("timer a event lost");

  property p_tc_set;
    @(posedge sys_clk) disable iff (!rst_b)
    timer_c_ovf |=> s_q.flags[4] || cpu_restart;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("timer c event lost");

  property p_conv_set;
    @(posedge sys_clk) disable iff (!rst_b)
    conv_done |=> s_q.flags[5] || cpu_restart;
  endproperty
  a_conv_set: assert property (p_conv_set) else $error("conversion event lost");

  property p_ser_set;
    @(posedge sys_clk) disable iff (!rst_b)
    (ser_done || ser_susp) |=> s_q.flags[6] || cpu_restart;
  endproperty
  a_ser_set: assert property (p_ser_set) else $error("serial event lost");

  // masked flags alone must never start the walk
  property p_masked;
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.seq == PIC_IDLE && (s_q.flags & ~s_q.masks) == 7'h00) |=> !irq_finish;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source accepted");

  property p_portb_keep;
    @(posedge sys_clk) disable iff (!rst_b)
    (cancel_now() && stop_mode) |=> port_mode_b_bit3 == $past(port_mode_b_bit3);
  endproperty
  a_portb_keep: assert property (p_portb_keep) else $error("port bit lost on stop-cancel");

  property p_restart_state;
    @(posedge sys_clk) disable iff (!rst_b)
    cpu_restart |-> s_q.flags == 7'h00 && s_q.masks == 7'h7f && !s_q.gie && vec_valid;
  endproperty
  a_restart_state: assert property (p_restart_state) else $error("restart left state behind");

  property p_push_window;
    @(posedge sys_clk) disable iff (!rst_b)
    irq_push |-> (s_q.seq == PIC_PUSH || s_q.seq == PIC_JUMP);
  endproperty
  a_push_window: assert property (p_push_window) else $error("push outside cycles two and three");
endmodule // pic_ctrl

//--- verif/pic_far_model.sv
/*
  far-side model: peripheral event sources and the cpu return sequencer of the interrupt controller.
  assumes: requests come from the bench just after a rising sys_clk edge.
*/
`timescale 1ns/1ps
module pic_far_model
  import pic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bench requests
  input wire pic_evt_t evt_req,
  input wire logic rti_req,
  input wire logic [3:0] rti_wait,
  // towards the controller
  output pic_evt_t evt,
  output logic rti
);
  logic [3:0] cnt_q;
  logic arm_q;
  // events leave one edge after the request; a one-cycle request gives a one-cycle pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt <= '0;
      rti <= 1'b0;
      cnt_q <= 4'h0;
      arm_q <= 1'b0;
    end else begin
      evt <= evt_req;
      rti <= 1'b0;
      // the return may come promptly or after rti_wait cycles, like a slow handler
      if (rti_req) begin
        arm_q <= 1'b1;
        cnt_q <= rti_wait;
      end else if (arm_q && cnt_q == 4'h0) begin
        rti <= 1'b1;
        arm_q <= 1'b0;
      end else if (arm_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // pic_far_model

//--- verif/prioritized_interrupt_controller_tb.sv
/*
  self-checking bench of the interrupt controller, one task per scenario.
  assumes: pic_far_model supplies event pulses and the return pulse.
*/
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb;
  import pic_pkg::*;
  logic sys_clk = 0, rst_b, reg_wr, reg_rd, ext_irq_input_0, ext_irq_input_1, stop_cancel_input, stop_mode;
  logic [3:0] reg_addr, reg_wdata, reg_rdata, rti_wait;
  logic rti_req, rti, irq_finish, irq_push, vec_valid, cpu_restart, ram_valid_flag, port_mode_b_bit3;
  logic [15:0] vec_addr;
  pic_evt_t evt_req, evt;
  int err_count = 0, num_checks = 0, cyc = 0, n_acc = 0, n_rst = 0;
  always #12.5 sys_clk = ~sys_clk;
  pic_far_model i_far (.sys_clk, .rst_b, .evt_req, .rti_req, .rti_wait, .evt, .rti);
  pic_ctrl i_dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_irq_input_0, .ext_irq_input_1, .stop_cancel_input, .timer_a_ovf(evt.timer_a),
    .timer_b_ovf(evt.timer_b), .timer_c_ovf(evt.timer_c), .conv_done(evt.conv_done),
    .ser_done(evt.ser_done), .ser_susp(evt.ser_susp), .stop_mode, .return_from_interrupt_instr(rti),
    .irq_finish, .irq_push, .vec_valid, .vec_addr, .cpu_restart, .ram_valid_flag, .port_mode_b_bit3);
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a hang costs a mismatch; the whole run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (irq_finish === 1'b1) n_acc++;
    if (cpu_restart === 1'b1) n_rst++;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [3:0] e);
    logic [3:0] d;
    rd(a, d);
    chk($sformatf("reg%0h", a), d, e);
  endtask
  task automatic acc(input logic kick, input logic [15:0] v);
    int i = 0;
    if (kick) begin
      rti_req <= 1'b1;
      @(posedge sys_clk);
      rti_req <= 1'b0;
    end
    // the walk may already have begun at the edge this task starts on
    #1;
    while (irq_finish !== 1'b1 && i < 20) begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk("finish", irq_finish, 1);
    @(posedge sys_clk);
    #1 chk("push", {irq_push, vec_valid}, 2'b10);
    @(posedge sys_clk);
    #1 chk("vector", {irq_push, vec_valid, vec_addr}, {2'b11, v});
    @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rc(4'h0, 4'h8);
    rc(4'h1, 4'hA);
    rc(4'h2, 4'hA);
    rc(4'h3, 4'hA);
    rc(4'hF, 4'h0);
    chk("ram_valid", ram_valid_flag, 0);
  endtask
  // all seven pending and unmasked; each return lets exactly the next one in
  task automatic t_prio;
    logic [3:0] ca[7] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3};
    logic [3:0] cd[7] = '{4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h4, 4'h0};
    logic [3:0] d;
    wr(4'h0, 4'h4);
    wr(4'h1, 4'h5);
    wr(4'h2, 4'h5);
    wr(4'h3, 4'h5);
    ext_irq_input_0 <= 1'b1;
    ext_irq_input_1 <= 1'b1;
    evt_req <= 6'b111110;
    @(posedge sys_clk);
    evt_req <= '0;
    repeat (6) @(posedge sys_clk);
    rc(4'h0, 4'h4);
    rc(4'h1, 4'h5);
    rc(4'h2, 4'h5);
    rc(4'h3, 4'h5);
    for (int k = 0; k < 7; k++) begin
      acc(1'b1, 16'h0002 + 16'(2 * k));
      rd(4'h0, d);
      chk("enable", d[0], 0);
      wr(ca[k], cd[k]);
    end
  endtask
  // everything pending but masked, enable set by a slow return; only serial gets unmasked
  task automatic t_mask;
    ext_irq_input_0 <= 1'b0;
    ext_irq_input_1 <= 1'b0;
    wr(4'h0, 4'h8);
    wr(4'h1, 4'hA);
    wr(4'h2, 4'hA);
    wr(4'h3, 4'hA);
    ext_irq_input_0 <= 1'b1;
    ext_irq_input_1 <= 1'b1;
    evt_req <= 6'b111101;
    rti_wait <= 4'h5;
    rti_req <= 1'b1;
    @(posedge sys_clk);
    evt_req <= '0;
    rti_req <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("accepts", 18'(n_acc), 18'd7);
    rc(4'h0, 4'hD);
    rc(4'h1, 4'hF);
    rc(4'h2, 4'hF);
    rc(4'h3, 4'hF);
    wr(4'h3, 4'h6);
    acc(1'b0, 16'h000E);
  endtask
  // overflow and clearing write meet at the same edge
  task automatic t_same;
    wr(4'h2, 4'h0);
    evt_req <= 6'b010000;
    @(posedge sys_clk);
    evt_req <= '0;
    wr(4'h2, 4'h0);
    rc(4'h2, 4'h1);
    wr(4'h2, 4'h0);
    rc(4'h2, 4'h0);
  endtask
  task automatic t_stop;
    int i = 0;
    wr(4'h5, 4'h8);
    stop_cancel_input <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("restarts", 18'(n_rst), 18'd0);
    stop_cancel_input <= 1'b0;
    stop_mode <= 1'b1;
    repeat (5) @(posedge sys_clk);
    stop_cancel_input <= 1'b1;
    do begin
      @(posedge sys_clk);
      #1 i++;
    end while (cpu_restart !== 1'b1 && i < 20);
    chk("restart", {cpu_restart, vec_valid, vec_addr}, {2'b11, 16'h0000});
    chk("ram_port", {ram_valid_flag, port_mode_b_bit3}, 2'b11);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    stop_cancel_input <= 1'b0;
    @(posedge sys_clk);
    rc(4'h0, 4'h8);
    rc(4'h4, 4'h8);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    #1 chk("ram_port", {ram_valid_flag, port_mode_b_bit3}, 2'b00);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask
  initial begin
    rst_b = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, rti_req, rti_wait} = '0;
    {ext_irq_input_0, ext_irq_input_1, stop_cancel_input, stop_mode} = '0;
    evt_req = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_prio;
    t_mask;
    t_same;
    t_stop;
    final_report;
  end
endmodule // prioritized_interrupt_controller_tb
